// File: include/asrd_pkg.sv
// Shared constants and carriers for the address space region decoder.
// Assumes a 32-bit core address and a 32-bit Avalon-MM register port.
package asrd_pkg;

   // Segments, one-hot; the code is chosen from the top three address bits and the user flag
   typedef enum logic [5:0] {
      SEG_USER   = 6'h01,
      SEG_LOW    = 6'h02,
      SEG_CACHED = 6'h04,
      SEG_UNCACH = 6'h08,
      SEG_HIGH   = 6'h10,
      SEG_IO     = 6'h20
   } asrd_seg_t;

   localparam int          VA_W        = 32;
   localparam int          EXT_W       = 29;
   localparam logic [2:0]  TOP_CACHED  = 3'h4;
   localparam logic [2:0]  TOP_UNCACH  = 3'h5;
   localparam logic [2:0]  TOP_HIGH    = 3'h6;
   localparam logic [2:0]  TOP_IO      = 3'h7;

   // On-chip I/O sub-windows and the on-chip RAM window, compared on address bits 31:24 (31:26 for the six-bit tops)
   localparam logic [5:0]  SQ_TOP6     = 6'h38;
   localparam logic [7:0]  WIN_IC_TAG  = 8'hf0;
   localparam logic [7:0]  WIN_IC_DATA = 8'hf1;
   localparam logic [7:0]  WIN_IT_ADDR = 8'hf2;
   localparam logic [7:0]  WIN_IT_DATA = 8'hf3;
   localparam logic [7:0]  WIN_OC_TAG  = 8'hf4;
   localparam logic [7:0]  WIN_OC_DATA = 8'hf5;
   localparam logic [7:0]  WIN_UT_ADDR = 8'hf6;
   localparam logic [7:0]  WIN_UT_DATA = 8'hf7;
   localparam logic [5:0]  CTRL_TOP6   = 6'h3f;
   localparam logic [5:0]  RAM_TOP6    = 6'h1f;

   // External space: eight areas selected by ext[28:26]
   localparam logic [2:0]  AREA_PCM_A  = 3'h5;
   localparam logic [2:0]  AREA_PCM_B  = 3'h6;
   localparam logic [2:0]  AREA_RSVD   = 3'h7;

   // Page sizes as coded in the translation result
   localparam logic [1:0]  PG_1K       = 2'h0;
   localparam logic [1:0]  PG_4K       = 2'h1;
   localparam logic [1:0]  PG_64K      = 2'h2;
   localparam logic [1:0]  PG_1M       = 2'h3;

   // Register map, byte addresses
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_FLAGS   = 4'h4;
   localparam logic [3:0]  REG_FADDR   = 4'h8;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

   // Control register bit positions
   localparam int B_XLATE   = 0;
   localparam int B_SQPRIV  = 1;
   localparam int B_SINGLE  = 2;
   localparam int B_CACHE   = 3;
   localparam int B_WTHRU   = 4;
   localparam int B_CBSEL   = 5;
   localparam int B_ORAM    = 6;
   localparam int B_ADDRESS_SPACE_ID_LO = 8;
   localparam int CTRL_USED = 16;

   // Flag register bit positions
   localparam int F_ADDRERR = 0;
   localparam int F_ITLBMIS = 1;
   localparam int F_UTLBMIS = 2;

   typedef struct packed {
      logic             valid;
      logic [VA_W-1:0]  addr;
      logic             fetch;
      logic             user;
   } asrd_req_t;

   typedef struct packed {
      logic             hit;
      logic [28:10]     ppn;
      logic [1:0]       size;
      logic             cacheable;
      logic             write_through;
      logic [2:0]       space_attr;
      logic             timing_sel;
   } asrd_tlb_t;

   typedef struct packed {
      logic             use_instr_xlate_buffer;
      logic             use_unified_xlate_buffer;
      logic [7:0]       address_space_id;
      logic             single_virtual;
   } asrd_lookup_t;

   typedef struct packed {
      asrd_seg_t        seg;
      logic [EXT_W-1:0] ext_addr;
      logic [2:0]       area;
      logic             translated;
      logic             cached;
      logic             write_through;
      logic             onchip_io;
      logic             store_queue;
      logic             ic_tag;
      logic             ic_data;
      logic             instr_xlate_buffer_addr;
      logic             instr_xlate_buffer_data;
      logic             oc_tag;
      logic             oc_data;
      logic             unified_xlate_buffer_addr;
      logic             unified_xlate_buffer_data;
      logic             ctrl_reg;
      logic             onchip_ram;
      logic             reserved;
      logic             pcmcia;
      logic [2:0]       space_attr;
      logic             timing_sel;
      logic             addr_error;
      logic             instr_xlate_buffer_miss;
      logic             unified_xlate_buffer_miss;
   } asrd_result_t;

endpackage : asrd_pkg

// File: src/asrd_decoder.sv
// Address space region decoder: classifies each core address, drives the
// TLB lookup and forms the external address, cache attributes and faults.
// Assumes the core presents one request per cycle and the TLB answers
// combinationally in the same cycle; registers sit on an Avalon-MM slave.
`timescale 1ns/1ns
module asrd_decoder (
   input  wire logic                   clock,
   input  wire logic                   reset,
   input  wire asrd_pkg::asrd_req_t    req,
   output      asrd_pkg::asrd_lookup_t lookup,
   input  wire asrd_pkg::asrd_tlb_t    tlb,
   output      asrd_pkg::asrd_result_t result,
   input  wire logic [3:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output      logic [31:0]            avs_readdata,
   output      logic                   avs_waitrequest
);

   // Physical address of a translated page: page number above, offset below
   function automatic logic [28:0] page_compose(input logic [28:10] ppn,
                                                input logic [1:0]   size,
                                                input logic [31:0]  va);
      logic [28:0] pa;
      pa = {ppn, va[9:0]};
      case (size)
         asrd_pkg::PG_4K:  pa[11:10] = va[11:10];
         asrd_pkg::PG_64K: pa[15:10] = va[15:10];
         asrd_pkg::PG_1M:  pa[19:10] = va[19:10];
         default:          pa = pa;
      endcase
      return pa;
   endfunction : page_compose

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return m;
   endfunction : lane_merge

   logic [31:0] ctrl;
   logic [2:0]  flags;
   logic [31:0] fault_addr;
   logic        ack;
   logic [31:0] next_ctrl;
   logic [2:0]  next_flags;
   logic [31:0] next_fault_addr;
   logic        next_ack;
   logic [31:0] next_readdata;

   logic xlate_on;
   logic sq_priv;
   logic cache_on;
   assign xlate_on = ctrl[asrd_pkg::B_XLATE];
   assign sq_priv  = ctrl[asrd_pkg::B_SQPRIV];
   assign cache_on = ctrl[asrd_pkg::B_CACHE];

   // Decode path is purely combinational so the core sees it in the request cycle
   always_comb begin
      logic [2:0]  top;
      logic [7:0]  top8;
      logic        is_sq;
      logic        mapped;
      logic        need_tlb;
      logic        user_bad;
      logic [28:0] direct_ext;
      top        = req.addr[31:29];
      top8       = req.addr[31:24];
      is_sq      = req.addr[31:26] == asrd_pkg::SQ_TOP6;
      direct_ext = req.addr[28:0];
      result     = '0;
      lookup     = '0;
      lookup.address_space_id           = ctrl[asrd_pkg::B_ADDRESS_SPACE_ID_LO +: 8];
      lookup.single_virtual = ctrl[asrd_pkg::B_SINGLE];

      if (req.user && !req.addr[31]) begin
         result.seg = asrd_pkg::SEG_USER;
      end else if (!req.addr[31]) begin
         result.seg = asrd_pkg::SEG_LOW;
      end else if (top == asrd_pkg::TOP_CACHED) begin
         result.seg = asrd_pkg::SEG_CACHED;
      end else if (top == asrd_pkg::TOP_UNCACH) begin
         result.seg = asrd_pkg::SEG_UNCACH;
      end else if (top == asrd_pkg::TOP_HIGH) begin
         result.seg = asrd_pkg::SEG_HIGH;
      end else begin
         result.seg = asrd_pkg::SEG_IO;
      end

      mapped = result.seg inside {asrd_pkg::SEG_USER, asrd_pkg::SEG_LOW,
                                  asrd_pkg::SEG_HIGH};
      result.onchip_ram = !req.addr[31] && ctrl[asrd_pkg::B_ORAM]
                          && req.addr[31:26] == asrd_pkg::RAM_TOP6;
      // Store queue may translate; RAM and direct segments never do
      need_tlb = xlate_on && ((mapped && !result.onchip_ram) || is_sq);

      // Privilege checks
      user_bad = req.user && req.addr[31] && !is_sq;
      if (req.user && is_sq && sq_priv) begin
         user_bad = 1'b1;
      end

      // On-chip I/O windows
      if (result.seg == asrd_pkg::SEG_IO) begin
         result.onchip_io   = 1'b1;
         result.store_queue = is_sq;
         result.ic_tag      = top8 == asrd_pkg::WIN_IC_TAG;
         result.ic_data     = top8 == asrd_pkg::WIN_IC_DATA;
         result.instr_xlate_buffer_addr   = top8 == asrd_pkg::WIN_IT_ADDR;
         result.instr_xlate_buffer_data   = top8 == asrd_pkg::WIN_IT_DATA;
         result.oc_tag      = top8 == asrd_pkg::WIN_OC_TAG;
         result.oc_data     = top8 == asrd_pkg::WIN_OC_DATA;
         result.unified_xlate_buffer_addr   = top8 == asrd_pkg::WIN_UT_ADDR;
         result.unified_xlate_buffer_data   = top8 == asrd_pkg::WIN_UT_DATA;
         result.ctrl_reg    = req.addr[31:26] == asrd_pkg::CTRL_TOP6;
      end

      if (need_tlb) begin
         lookup.use_instr_xlate_buffer   = req.valid && req.fetch;
         lookup.use_unified_xlate_buffer   = req.valid && !req.fetch;
         result.translated = 1'b1;
         result.ext_addr   = page_compose(tlb.ppn, tlb.size, req.addr);
         result.area       = result.ext_addr[28:26];
         // Area 7 behind a page is the control register window
         result.ctrl_reg   = result.area == asrd_pkg::AREA_RSVD;
         result.cached     = cache_on && tlb.cacheable && !is_sq;
         result.write_through = tlb.write_through;
         result.pcmcia     = result.area == asrd_pkg::AREA_PCM_A
                             || result.area == asrd_pkg::AREA_PCM_B;
         if (result.pcmcia) begin
            result.space_attr = tlb.space_attr;
            result.timing_sel = tlb.timing_sel;
         end
         if (req.valid && !tlb.hit && !user_bad) begin
            result.instr_xlate_buffer_miss = req.fetch;
            result.unified_xlate_buffer_miss = !req.fetch;
         end
      end else if (result.seg != asrd_pkg::SEG_IO && !result.onchip_ram) begin
         result.ext_addr = direct_ext;
         result.area     = direct_ext[28:26];
         result.reserved = result.area == asrd_pkg::AREA_RSVD;
         result.pcmcia   = result.area == asrd_pkg::AREA_PCM_A
                           || result.area == asrd_pkg::AREA_PCM_B;
         if (result.seg == asrd_pkg::SEG_CACHED) begin
            result.cached        = cache_on;
            result.write_through = !ctrl[asrd_pkg::B_CBSEL];
         end else if (result.seg != asrd_pkg::SEG_UNCACH) begin
            result.cached        = cache_on;
            result.write_through = ctrl[asrd_pkg::B_WTHRU];
         end
         // The cached and uncached segments cannot reach the PC Card areas at all
         if (result.seg inside {asrd_pkg::SEG_CACHED, asrd_pkg::SEG_UNCACH}
             && result.pcmcia) begin
            user_bad = 1'b1;
         end
      end

      result.addr_error = req.valid && user_bad;
   end

   // Register slave and fault capture
   always_comb begin
      logic wr_go;
      wr_go           = avs_write && ack;
      next_ctrl       = ctrl;
      next_flags      = flags;
      next_fault_addr = fault_addr;
      next_ack        = (avs_read || avs_write) && !ack;
      next_readdata   = avs_readdata;
      if (wr_go && avs_address == asrd_pkg::REG_CTRL) begin
         next_ctrl = lane_merge(ctrl, avs_writedata, avs_byteenable);
         next_ctrl[31:asrd_pkg::CTRL_USED] = '0;
         next_ctrl[7] = 1'b0;
      end
      if (wr_go && avs_address == asrd_pkg::REG_FLAGS && avs_byteenable[0]) begin
         next_flags = flags & ~avs_writedata[2:0];
      end
      // A new fault in the clearing cycle survives the clear
      if (result.addr_error || result.instr_xlate_buffer_miss || result.unified_xlate_buffer_miss) begin
         next_flags[asrd_pkg::F_ADDRERR] = next_flags[asrd_pkg::F_ADDRERR] | result.addr_error;
         next_flags[asrd_pkg::F_ITLBMIS] = next_flags[asrd_pkg::F_ITLBMIS] | result.instr_xlate_buffer_miss;
         next_flags[asrd_pkg::F_UTLBMIS] = next_flags[asrd_pkg::F_UTLBMIS] | result.unified_xlate_buffer_miss;
         next_fault_addr = req.addr;
      end
      if (avs_read && !ack) begin
         if (avs_address == asrd_pkg::REG_CTRL) begin
            next_readdata = ctrl;
         end else if (avs_address == asrd_pkg::REG_FLAGS) begin
            next_readdata = {29'h0000_0000, flags};
         end else if (avs_address == asrd_pkg::REG_FADDR) begin
            next_readdata = fault_addr;
         end else begin
            next_readdata = 32'h0000_0000;
         end
      end
   end

   // One wait state: the request is answered at the second edge it is seen
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl         <= asrd_pkg::CTRL_RESET;
         flags        <= 3'h0;
         fault_addr   <= 32'h0000_0000;
         ack          <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ctrl         <= next_ctrl;
         flags        <= next_flags;
         fault_addr   <= next_fault_addr;
         ack          <= next_ack;
         avs_readdata <= next_readdata;
      end
   end

endmodule : asrd_decoder

// File: test/asrd_props.sv
// Assertion checker for the region decoder, bound to its top module.
// Sees only decoder ports; the control register itself is not checked here.
`timescale 1ns/1ns
module asrd_props (
   input wire logic                   clock,
   input wire logic                   reset,
   input wire asrd_pkg::asrd_req_t    req,
   input wire asrd_pkg::asrd_lookup_t lookup,
   input wire asrd_pkg::asrd_tlb_t    tlb,
   input wire asrd_pkg::asrd_result_t result,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   AST_SEG_IO: assert property (
      !req.user && req.addr[31:29] == asrd_pkg::TOP_IO |->
      result.seg == asrd_pkg::SEG_IO && result.onchip_io && !result.cached)
      else $error("on-chip segment decode wrong");
   AST_USER_ERR: assert property (
      req.valid && req.user && req.addr[31] && req.addr[31:26] != asrd_pkg::SQ_TOP6
      |-> result.addr_error) else $error("user access to upper half not refused");
   AST_UNCACHED: assert property (
      result.seg == asrd_pkg::SEG_UNCACH |-> !result.cached && !result.translated
      && result.ext_addr == req.addr[28:0] && result.area == req.addr[28:26])
      else $error("uncached segment mapping wrong");
   AST_SQ_WIN: assert property (
      req.addr[31:26] == asrd_pkg::SQ_TOP6 |-> result.store_queue && !result.cached)
      else $error("store queue window missed");
   AST_CTRL_WIN: assert property (
      req.addr[31:26] == asrd_pkg::CTRL_TOP6 |-> result.ctrl_reg)
      else $error("control register area missed");
   AST_NO_SEARCH: assert property (
      !(lookup.use_instr_xlate_buffer || lookup.use_unified_xlate_buffer) |-> !result.instr_xlate_buffer_miss && !result.unified_xlate_buffer_miss)
      else $error("miss without a search");
   AST_INSTR_XLATE_BUFFER_FETCH: assert property (
      lookup.use_instr_xlate_buffer |-> req.fetch && req.valid) else $error("data used instr buffer");
   AST_UNIFIED_XLATE_BUFFER_MISS: assert property (
      lookup.use_unified_xlate_buffer && !tlb.hit && !result.addr_error |-> result.unified_xlate_buffer_miss)
      else $error("unified miss not raised");
   AST_XL_CACHE: assert property (
      result.translated && !tlb.cacheable |-> !result.cached)
      else $error("uncacheable page cached");
   AST_AREA7: assert property (
      result.translated && tlb.hit && tlb.ppn[28:26] == asrd_pkg::AREA_RSVD
      |-> result.ctrl_reg && !result.reserved) else $error("translated area 7 wrong");
   AST_WAIT_ONE: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   cover property (result.unified_xlate_buffer_miss);
   cover property (result.translated && result.cached);
   cover property (req.user && result.store_queue);
endmodule : asrd_props

bind asrd_decoder asrd_props asrd_props_i (.clock(clock), .reset(reset), .req(req),
   .lookup(lookup), .tlb(tlb), .result(result), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// File: test/asrd_tlb_model.sv
// Far-side translation buffer model: answers a lookup in the same cycle.
// Assumes the bench sets the page it hands back; nothing is stored here.
`timescale 1ns/1ns
module asrd_tlb_model #(
   parameter logic [7:0] OWN_ADDRESS_SPACE_ID = 8'h5a
) (
   input  wire asrd_pkg::asrd_lookup_t lookup,
   input  wire logic                   hit_en,
   input  wire asrd_pkg::asrd_tlb_t    page,
   output      asrd_pkg::asrd_tlb_t    tlb
);
   always_comb begin
      if (lookup.use_instr_xlate_buffer || lookup.use_unified_xlate_buffer) begin
         tlb = page;
         tlb.hit = hit_en && (lookup.address_space_id == OWN_ADDRESS_SPACE_ID);
         // Software never leaves control register pages cacheable
         if (page.ppn[28:24] == 5'h1f) tlb.cacheable = 1'b0;
      end else begin
         // No search: show a changed answer so a stale one is never trusted
         tlb = ~page;
         tlb.hit = 1'b0;
      end
   end
endmodule : asrd_tlb_model

// File: test/tb_top.sv
// Self-checking bench for the region decoder with a translation buffer model.
// Assumes one core request per cycle and a two-cycle register bus access.
`timescale 1ns/1ns
module tb_top;
   logic                   clock = 1'b0;
   logic                   reset = 1'b1;
   asrd_pkg::asrd_req_t    req = '0;
   asrd_pkg::asrd_lookup_t lookup;
   asrd_pkg::asrd_tlb_t    tlb;
   asrd_pkg::asrd_result_t result;
   logic [3:0]             avs_address = 4'h0;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h0;
   logic [3:0]             avs_byteenable = 4'hf;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic                   hit_en = 1'b0;
   asrd_pkg::asrd_tlb_t    page = '0;
   logic [31:0]            rd;
   logic                   ca;
   int                     n_mismatch = 0;
   int                     comparisons = 0;
   wire [7:0] win = {result.ic_tag, result.ic_data, result.instr_xlate_buffer_addr, result.instr_xlate_buffer_data,
                     result.oc_tag, result.oc_data, result.unified_xlate_buffer_addr, result.unified_xlate_buffer_data};

   always #50 clock = ~clock;

   asrd_decoder asrd_decoder_i (.clock(clock), .reset(reset), .req(req), .lookup(lookup),
      .tlb(tlb), .result(result), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   asrd_tlb_model asrd_tlb_model_i (.lookup(lookup), .hit_en(hit_en), .page(page),
      .tlb(tlb));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      // Held until waitrequest is seen low at a rising edge
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         test_done();
      end
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask : rchk

   task automatic go(input logic [31:0] a, input logic f, input logic u);
      @(posedge clock);
      req <= '{1'b1, a, f, u};
      @(negedge clock);
   endtask : go

   function automatic logic [28:0] xl(input logic [18:0] p, input int s,
                                      input logic [31:0] a);
      logic [28:0] m;
      m = (29'h1 << (s == 0 ? 10 : s == 1 ? 12 : s == 2 ? 16 : 20)) - 29'h1;
      return ({p, 10'h0} & ~m) | (a[28:0] & m);
   endfunction : xl

   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   initial begin
      #1_000_000;
      n_mismatch++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      rchk("ctrl", asrd_pkg::REG_CTRL, asrd_pkg::CTRL_RESET);
      rchk("flags", asrd_pkg::REG_FLAGS, 32'h0);
      bus(1'b1, 4'hc, 32'hffff_ffff);
      rchk("unmapped", 4'hc, 32'h0);
      bus(1'b1, asrd_pkg::REG_CTRL, 32'hffff_ffff);
      rchk("ctrl", asrd_pkg::REG_CTRL, 32'h0000_ff7f);
      check("single", 1'b1, lookup.single_virtual);
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, asrd_pkg::REG_CTRL, j == 0 ? 32'h38 : 32'h08);
         for (int t = 0; t < 8; t++) begin
            if (t == 0 || t > 3) begin
               go({3'(t), 29'h1234_5678}, 1'b0, 1'b0);
               ca = (t != 5 && t != 7);
               check("seg", 32'h02 << (t == 0 ? 0 : t - 3), result.seg);
               check("cached", ca, result.cached);
               if (ca) check("wthru", (t == 4) == (j == 1), result.write_through);
               if (t < 7) check("ext", 29'h1234_5678, result.ext_addr);
            end
         end
      end
      for (int i = 0; i < 8; i++) begin
         go({8'hf0 + 8'(i), 24'h00_0010}, 1'b0, 1'b0);
         check("window", 32'h80 >> i, win);
      end
      go(32'hfc00_0000, 1'b0, 1'b0);
      check("ctrl area", 1'b1, result.ctrl_reg);
      go(32'he3ff_fffc, 1'b0, 1'b0);
      check("sq", 1'b1, result.store_queue);
      go(32'he400_0000, 1'b0, 1'b0);
      check("sq", 1'b0, result.store_queue);
      go(32'hbc00_0000, 1'b0, 1'b0);
      check("reserved", 1'b1, result.reserved);
      check("area", 3'h7, result.area);
      go(32'hb400_0000, 1'b0, 1'b0);
      check("direct pcmcia", 1'b1, result.addr_error);
      go(32'h8000_0000, 1'b0, 1'b1);
      check("user err", 1'b1, result.addr_error);
      go(32'h7fff_fff0, 1'b0, 1'b1);
      check("user err", 1'b0, result.addr_error);
      go(32'he000_0040, 1'b0, 1'b1);
      check("user sq", 1'b0, result.addr_error);
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h0a);
      go(32'he000_0040, 1'b0, 1'b1);
      check("user sq", 1'b1, result.addr_error);
      go(32'h0000_0040, 1'b0, 1'b0);
      rchk("flags", asrd_pkg::REG_FLAGS, 32'h1);
      rchk("fault addr", asrd_pkg::REG_FADDR, 32'he000_0040);
      bus(1'b1, asrd_pkg::REG_FLAGS, 32'h7);
      rchk("flags", asrd_pkg::REG_FLAGS, 32'h0);
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h5a09);
      hit_en <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         page <= '{1'b1, 19'h0_4567, 2'(s), 1'b1, s[0], 3'h0, 1'b0};
         go(32'h0012_3456 + s, 1'b0, 1'b0);
         check("xlated", 1'b1, result.translated);
         check("ext", xl(19'h0_4567, s, 32'h0012_3456 + s), result.ext_addr);
         check("unified_xlate_buffer", 1'b1, lookup.use_unified_xlate_buffer);
         check("address_space_id", 8'h5a, lookup.address_space_id);
         check("cached", 1'b1, result.cached);
         check("wthru", s[0], result.write_through);
      end
      go(32'h0012_3456, 1'b1, 1'b0);
      check("instr_xlate_buffer", 1'b1, lookup.use_instr_xlate_buffer);
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h3309);
      go(32'h0000_2000, 1'b0, 1'b0);
      check("miss", 1'b1, result.unified_xlate_buffer_miss);
      go(32'ha000_0000, 1'b0, 1'b0);
      check("direct", 1'b0, result.translated);
      // The fetch still presented when the id changed misses as well
      rchk("flags", asrd_pkg::REG_FLAGS, 32'h6);
      rchk("fault addr", asrd_pkg::REG_FADDR, 32'h0000_2000);
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h5a09);
      page <= '{1'b1, 19'h7_c000, 2'h1, 1'b1, 1'b0, 3'h0, 1'b0};
      go(32'h0000_0100, 1'b0, 1'b0);
      check("area7", 2'h2, {result.ctrl_reg, result.reserved});
      check("cached", 1'b0, result.cached);
      page <= '{1'b1, 19'h5_0000, 2'h1, 1'b0, 1'b0, 3'h5, 1'b1};
      go(32'h0000_0100, 1'b0, 1'b0);
      check("pcmcia", 5'h1b, {result.pcmcia, result.space_attr, result.timing_sel});
      go(32'he000_0040, 1'b0, 1'b0);
      check("sq xlate", 2'h2, {result.translated, result.cached});
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h5a49);
      go(32'h7c00_0010, 1'b0, 1'b0);
      check("ram", 2'h2, {result.onchip_ram, result.translated});
      bus(1'b1, asrd_pkg::REG_CTRL, 32'h08);
      hit_en <= 1'b0;
      go(32'hc000_1000, 1'b1, 1'b0);
      check("no miss", 2'h0, {result.instr_xlate_buffer_miss, result.unified_xlate_buffer_miss});
      check("ext", 29'h0000_1000, result.ext_addr);
      test_done();
   end
endmodule : tb_top
